// >>> core/scc_regs.vh
// Constants for the serial channel control and status block.
// Assumes a single 20 MHz clock and no register bus; all controls are ports.
`ifndef SCC_REGS_VH
`define SCC_REGS_VH
`define SCC_ADDR_W        9
`define SCC_DATA_W        16
`define SCC_CFG_DEPTH     512
`define SCC_ACK_LAT       4'h3
`define SCC_BUSY_PERIOD   16'h0fff
`define SCC_BUSY_LEN      5'h10
`define SCC_ANALOG_RST_NS 1000
`define SCC_CODING_RST_NS 500
`define SCC_CLK_NS        50
`define SCC_ANALOG_CYC    ((`SCC_ANALOG_RST_NS + `SCC_CLK_NS - 1) / `SCC_CLK_NS)
`define SCC_CODING_CYC    ((`SCC_CODING_RST_NS + `SCC_CLK_NS - 1) / `SCC_CLK_NS)
`define SCC_CFG_RESET     16'h0000
`define SCC_PRBS7         3'h1
`define SCC_PRBS15        3'h2
`define SCC_PRBS23        3'h3
`define SCC_PRBS31        3'h4
`endif

// >>> core/scc_reset_seq.v
// Reset sequencer for one direction: analog phase then coding phase.
// Assumes start inputs are synchronous single-cycle or level requests.
`timescale 1ns/1ns
`default_nettype none
`include "scc_regs.vh"
module scc_reset_seq #(
  parameter [7:0] ANALOG_CYC = 8'd20,
  parameter [7:0] CODING_CYC = 8'd10
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       analog_start,
  input  wire       coding_start,
  output reg        analog_done,
  output reg        all_done
);
  localparam [2:0] S_ANALOG = 3'b001;
  localparam [2:0] S_CODING = 3'b010;
  localparam [2:0] S_READY  = 3'b100;
  reg [2:0] state;
  reg [7:0] count;

  // An analog start restarts both phases; a coding start redoes only coding.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= S_ANALOG;
      count       <= 8'h00;
      analog_done <= 1'b0;
      all_done    <= 1'b0;
    end else if (analog_start) begin
      state       <= S_ANALOG;
      count       <= 8'h00;
      analog_done <= 1'b0;
      all_done    <= 1'b0;
    end else if (coding_start) begin
      state    <= S_CODING;
      count    <= 8'h00;
      all_done <= 1'b0;
    end else begin
      case (state)
        S_ANALOG: begin
          if (count == ANALOG_CYC - 8'd1) begin
            state       <= S_CODING;
            count       <= 8'h00;
            analog_done <= 1'b1;
          end else begin
            count <= count + 8'd1;
          end
        end
        S_CODING: begin
          if (count == CODING_CYC - 8'd1) begin
            state    <= S_READY;
            all_done <= 1'b1;
          end else begin
            count <= count + 8'd1;
          end
        end
        S_READY: begin
          state <= S_READY;
        end
        default: begin
          state <= S_ANALOG;
        end
      endcase
    end
  end
endmodule // scc_reset_seq
`default_nettype wire

// >>> core/scc_lfsr.v
// Pattern generator / reference: a 31-bit shift register with selectable taps.
// Assumes advance is a one-cycle enable; seed is restored on load.
`timescale 1ns/1ns
`default_nettype none
`include "scc_regs.vh"
module scc_lfsr (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        advance,
  input  wire        load,
  input  wire [30:0] seed,
  input  wire [2:0]  pattern,
  output wire        bit_out,
  output reg  [30:0] state
);
  reg fb;

  // Feedback tap pair per pattern; an unknown code falls back to the shortest.
  always @* begin
    case (pattern)
      `SCC_PRBS15: fb = state[14] ^ state[13];
      `SCC_PRBS23: fb = state[22] ^ state[17];
      `SCC_PRBS31: fb = state[30] ^ state[27];
      default:     fb = state[6] ^ state[5];
    endcase
  end

  assign bit_out = fb;

  // Never let the register reach all zeros, or it would lock up.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= 31'h7fffffff;
    end else if (load) begin
      state <= (seed == 31'h00000000) ? 31'h7fffffff : seed;
    end else if (advance) begin
      state <= {state[29:0], fb};
    end
  end
endmodule // scc_lfsr
`default_nettype wire

// >>> core/scc_lane.v
// One lane of the channel control and status port set.
// Assumes every input is synchronous to CLK; instantiate once per lane.
`timescale 1ns/1ns
`default_nettype none
`include "scc_regs.vh"
module scc_lane (
  input  wire        CLK,
  input  wire        RST_N,
  input  wire [8:0]  RECONFIG_ADDRESS,
  input  wire        RECONFIG_STROBE,
  input  wire [15:0] RECONFIG_WRITE_DATA,
  input  wire        RECONFIG_WRITE_SELECT,
  output reg  [15:0] RECONFIG_READ_DATA,
  output reg         RECONFIG_ACK,
  output wire        RECONFIG_IN_USE,
  input  wire        TX_ANALOG_RESET_START,
  input  wire        TX_CODING_RESET_START,
  output wire        TX_RESET_COMPLETE,
  input  wire        RX_ANALOG_RESET_START,
  input  wire        RX_CODING_RESET_START,
  output wire        RX_ANALOG_RESET_COMPLETE,
  output wire        RX_RESET_COMPLETE,
  input  wire        MARGIN_SCAN_RESET,
  input  wire        MARGIN_SCAN_TRIGGER,
  input  wire        MARGIN_SCAN_ERROR_MASK,
  output reg         MARGIN_SCAN_ERROR_PULSE,
  input  wire [2:0]  LANE_LOOP_SELECT,
  input  wire        RX_INVERT,
  input  wire        TX_INVERT,
  input  wire        RX_EQUALISER_MODE,
  input  wire [1:0]  RX_PROBE_SELECT,
  output reg  [6:0]  RX_PROBE_VALUE,
  input  wire        LINEAR_EQUALISER_RESET,
  input  wire        PATTERN_ERROR_COUNT_CLEAR,
  output reg         PATTERN_ERROR_FLAG,
  output reg  [15:0] PATTERN_ERROR_COUNT,
  input  wire [2:0]  RX_PATTERN_SELECT,
  input  wire [2:0]  TX_PATTERN_SELECT,
  input  wire        PATTERN_ERROR_INJECT,
  input  wire        RECOVERY_LOOP_FREEZE,
  input  wire        RX_SERIAL_IN,
  output reg         TX_SERIAL_OUT,
  input  wire [3:0]  RX_BYTE_DISPARITY_IN,
  input  wire [3:0]  RX_BYTE_CODE_VALID_N,
  output reg  [3:0]  RX_BYTE_DISPARITY_FAULT,
  output reg  [3:0]  RX_BYTE_INVALID_CODE
);
  localparam [2:0] A_IDLE = 3'b001;
  localparam [2:0] A_WAIT = 3'b010;
  localparam [2:0] A_DONE = 3'b100;
  localparam [2:0] M_IDLE = 3'b001;
  localparam [2:0] M_WAIT = 3'b010;
  localparam [2:0] M_COUNT = 3'b100;
  localparam [2:0] LOOP_NEAR_PCS = 3'h1;
  localparam [2:0] LOOP_NEAR_PMA = 3'h2;
  // Cycle counts are worked out at full width and cut to the sequencer's width on purpose.
  localparam [31:0] ANALOG_CYC_FULL = `SCC_ANALOG_CYC;
  localparam [31:0] CODING_CYC_FULL = `SCC_CODING_CYC;

  // Configuration space held in flip-flops.
  reg [15:0] cfg_mem [0:`SCC_CFG_DEPTH-1];
  reg [2:0]  acc_state;
  reg [3:0]  acc_wait;
  reg        acc_write;
  reg [8:0]  acc_addr;
  reg [15:0] acc_data;
  reg [15:0] busy_timer;
  reg [4:0]  busy_len;
  reg [2:0]  scan_state;
  reg        scan_reset_d;
  reg [6:0]  recovery_phase;
  reg [6:0]  eq_adapt;
  reg        eq_reset_d;
  reg        tx_err_toggle;
  reg        rx_data;
  wire       tx_bit;
  wire       ref_bit;
  wire [30:0] tx_state;
  wire [30:0] rx_ref_state;
  wire       rx_analog_done;
  wire       rx_done;
  wire       tx_done;
  wire       pattern_mismatch;
  integer    i;

  assign RECONFIG_IN_USE = (busy_len != 5'h00);

  // Periodic internal calibration claims the port only while no request is up,
  // so busy never rises under an access that was already offered.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      busy_timer <= 16'h0000;
      busy_len   <= 5'h00;
    end else if (busy_len != 5'h00) begin
      busy_len <= busy_len - 5'h01;
    end else if (busy_timer == `SCC_BUSY_PERIOD && acc_state == A_IDLE &&
                 !RECONFIG_STROBE) begin
      busy_timer <= 16'h0000;
      busy_len   <= `SCC_BUSY_LEN;
    end else if (busy_timer != `SCC_BUSY_PERIOD) begin
      busy_timer <= busy_timer + 16'h0001;
    end
  end

  // Each strobe is taken once; the access is acknowledged a fixed latency later.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      acc_state          <= A_IDLE;
      acc_wait           <= 4'h0;
      acc_write          <= 1'b0;
      acc_addr           <= 9'h000;
      acc_data           <= 16'h0000;
      RECONFIG_ACK       <= 1'b0;
      RECONFIG_READ_DATA <= 16'h0000;
      for (i = 0; i < `SCC_CFG_DEPTH; i = i + 1) begin
        cfg_mem[i] <= `SCC_CFG_RESET;
      end
    end else begin
      RECONFIG_ACK <= 1'b0;
      case (acc_state)
        A_IDLE: begin
          // A strobe still up in the acknowledge cycle belongs to the finished access.
          if (RECONFIG_STROBE && !RECONFIG_IN_USE && !RECONFIG_ACK) begin
            acc_write <= RECONFIG_WRITE_SELECT;
            acc_addr  <= RECONFIG_ADDRESS;
            acc_data  <= RECONFIG_WRITE_DATA;
            acc_wait  <= `SCC_ACK_LAT;
            acc_state <= A_WAIT;
          end
        end
        A_WAIT: begin
          if (acc_wait == 4'h1) begin
            acc_state <= A_DONE;
          end
          acc_wait <= acc_wait - 4'h1;
        end
        A_DONE: begin
          if (acc_write) begin
            cfg_mem[acc_addr] <= acc_data;
          end else begin
            RECONFIG_READ_DATA <= cfg_mem[acc_addr];
          end
          RECONFIG_ACK <= 1'b1;
          acc_state    <= A_IDLE;
        end
        default: begin
          acc_state <= A_IDLE;
        end
      endcase
    end
  end

  // Transmit and receive reset sequences run independently.
  scc_reset_seq #(
    .ANALOG_CYC (ANALOG_CYC_FULL[7:0]),
    .CODING_CYC (CODING_CYC_FULL[7:0])
  ) u_tx_rst (
    .clk          (CLK),
    .rst_n        (RST_N),
    .analog_start (TX_ANALOG_RESET_START),
    .coding_start (TX_CODING_RESET_START),
    .analog_done  (),
    .all_done     (tx_done)
  );

  scc_reset_seq #(
    .ANALOG_CYC (ANALOG_CYC_FULL[7:0]),
    .CODING_CYC (CODING_CYC_FULL[7:0])
  ) u_rx_rst (
    .clk          (CLK),
    .rst_n        (RST_N),
    .analog_start (RX_ANALOG_RESET_START),
    .coding_start (RX_CODING_RESET_START),
    .analog_done  (rx_analog_done),
    .all_done     (rx_done)
  );

  assign TX_RESET_COMPLETE        = tx_done;
  assign RX_RESET_COMPLETE        = rx_done;
  assign RX_ANALOG_RESET_COMPLETE = rx_analog_done;

  // Transmit generator; injection flips one bit every other cycle while held.
  scc_lfsr u_tx_gen (
    .clk     (CLK),
    .rst_n   (RST_N),
    .advance (tx_done),
    .load    (!tx_done),
    .seed    (31'h7fffffff),
    .pattern (TX_PATTERN_SELECT),
    .bit_out (tx_bit),
    .state   (tx_state)
  );

  // Loopback modes route the transmitted line, forced errors included, onto the receive path.
  always @* begin
    case (LANE_LOOP_SELECT)
      LOOP_NEAR_PCS: rx_data = TX_SERIAL_OUT ^ RX_INVERT;
      LOOP_NEAR_PMA: rx_data = TX_SERIAL_OUT ^ RX_INVERT;
      default:       rx_data = RX_SERIAL_IN ^ RX_INVERT;
    endcase
  end

  // Receive checker is self-seeding: it shifts in each received bit, so its prediction
  // locks to the incoming stream after one register length, whatever the far phase.
  scc_lfsr u_rx_chk (
    .clk     (CLK),
    .rst_n   (RST_N),
    .advance (1'b0),
    .load    (rx_done),
    .seed    ({rx_ref_state[29:0], rx_data}),
    .pattern (RX_PATTERN_SELECT),
    .bit_out (ref_bit),
    .state   (rx_ref_state)
  );

  assign pattern_mismatch = rx_done && (RX_PATTERN_SELECT != 3'h0) && (rx_data != ref_bit);

  // Serial output, inverted on request, with errors forced during injection.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      TX_SERIAL_OUT <= 1'b0;
      tx_err_toggle <= 1'b0;
    end else begin
      tx_err_toggle <= PATTERN_ERROR_INJECT ? ~tx_err_toggle : 1'b0;
      TX_SERIAL_OUT <= tx_bit ^ TX_INVERT ^ (PATTERN_ERROR_INJECT & ~tx_err_toggle);
    end
  end

  // The flag is live, never sticky; the counter saturates rather than wraps.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PATTERN_ERROR_FLAG  <= 1'b0;
      PATTERN_ERROR_COUNT <= 16'h0000;
    end else begin
      PATTERN_ERROR_FLAG <= pattern_mismatch;
      if (PATTERN_ERROR_COUNT_CLEAR) begin
        PATTERN_ERROR_COUNT <= 16'h0000;
      end else if (pattern_mismatch && PATTERN_ERROR_COUNT != 16'hffff) begin
        PATTERN_ERROR_COUNT <= PATTERN_ERROR_COUNT + 16'h0001;
      end
    end
  end

  // Margin scan: held idle while the reset is high; the scan arms on the falling edge of the reset pulse.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      scan_state              <= M_IDLE;
      scan_reset_d            <= 1'b0;
      MARGIN_SCAN_ERROR_PULSE <= 1'b0;
    end else begin
      scan_reset_d            <= MARGIN_SCAN_RESET;
      MARGIN_SCAN_ERROR_PULSE <= 1'b0;
      case (scan_state)
        M_IDLE: begin
          if (scan_reset_d && !MARGIN_SCAN_RESET) begin
            scan_state <= M_WAIT;
          end
        end
        M_WAIT: begin
          if (MARGIN_SCAN_TRIGGER) begin
            scan_state <= M_COUNT;
          end
        end
        M_COUNT: begin
          scan_state <= M_COUNT;
        end
        default: begin
          scan_state <= M_IDLE;
        end
      endcase
      if (MARGIN_SCAN_RESET) begin
        scan_state <= M_IDLE;
      end else if ((scan_state == M_WAIT || scan_state == M_COUNT) &&
                   pattern_mismatch && !MARGIN_SCAN_ERROR_MASK) begin
        MARGIN_SCAN_ERROR_PULSE <= 1'b1;
      end
    end
  end

  // Recovery phase steps on each cycle the received bit is high unless frozen; equaliser adapts in either mode.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      recovery_phase <= 7'h00;
      eq_adapt       <= 7'h00;
      eq_reset_d     <= 1'b0;
    end else begin
      eq_reset_d <= LINEAR_EQUALISER_RESET;
      if (!RECOVERY_LOOP_FREEZE && rx_data) begin
        recovery_phase <= recovery_phase + 7'h01;
      end
      if (eq_reset_d && !LINEAR_EQUALISER_RESET) begin
        eq_adapt <= 7'h00;
      end else if (RX_EQUALISER_MODE) begin
        eq_adapt <= {1'b0, eq_adapt[6:1]} + 7'h01;
      end else if (eq_adapt != 7'h7f) begin
        eq_adapt <= eq_adapt + 7'h01;
      end
    end
  end

  // Probe output and per-byte decode flags, registered.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RX_PROBE_VALUE          <= 7'h00;
      RX_BYTE_DISPARITY_FAULT <= 4'h0;
      RX_BYTE_INVALID_CODE    <= 4'h0;
    end else begin
      case (RX_PROBE_SELECT)
        2'h0:    RX_PROBE_VALUE <= 7'h00;
        2'h1:    RX_PROBE_VALUE <= eq_adapt;
        2'h2:    RX_PROBE_VALUE <= recovery_phase;
        default: RX_PROBE_VALUE <= rx_ref_state[6:0];
      endcase
      RX_BYTE_DISPARITY_FAULT <= rx_done ? RX_BYTE_DISPARITY_IN : 4'h0;
      RX_BYTE_INVALID_CODE    <= rx_done ? RX_BYTE_CODE_VALID_N : 4'h0;
    end
  end
  // Nothing here is shared with another lane instance.
endmodule // scc_lane
`default_nettype wire

// >>> dv/scc_ctrl_model.sv
// Controller model that drives the lane's reconfiguration port.
// Assumes one CLK; the bench calls access() from just after a clock edge.
`timescale 1ns/1ns
`default_nettype none
module scc_ctrl_model (
  input  wire logic        CLK,
  input  wire logic        RECONFIG_ACK,
  input  wire logic        RECONFIG_IN_USE,
  input  wire logic [15:0] RECONFIG_READ_DATA,
  output var  logic [8:0]  RECONFIG_ADDRESS,
  output var  logic        RECONFIG_STROBE,
  output var  logic        RECONFIG_WRITE_SELECT,
  output var  logic [15:0] RECONFIG_WRITE_DATA
);
  // The port starts idle.
  initial begin
    RECONFIG_STROBE = 1'b0;
    RECONFIG_WRITE_SELECT = 1'b0;
    RECONFIG_ADDRESS = 9'h000;
    RECONFIG_WRITE_DATA = 16'h0000;
  end
  // One access, held until ack is sampled, so a refused take is simply retried.
  task automatic access(input logic we, input logic [8:0] a, input logic [15:0] d,
                        output logic [15:0] q, output int n);
    n = 0;
    @(posedge CLK);
    #5;
    while (RECONFIG_IN_USE !== 1'b0 && n < 100) begin
      @(posedge CLK);
      #5;
      n++;
    end
    n = 0;
    RECONFIG_STROBE = 1'b1;
    RECONFIG_WRITE_SELECT = we;
    RECONFIG_ADDRESS = a;
    RECONFIG_WRITE_DATA = d;
    // Look just after each edge, once the registered ack has settled.
    do begin
      @(posedge CLK);
      #1;
      n++;
    end while (RECONFIG_ACK !== 1'b1 && n < 60);
    q = RECONFIG_READ_DATA;
    // Hold the request through the edge at which the ack is sampled high.
    @(posedge CLK);
    #5;
    RECONFIG_STROBE = 1'b0;
    // Released address and data lines change, so a design cannot lean on stale values.
    RECONFIG_ADDRESS = ~a;
    RECONFIG_WRITE_DATA = ~d;
  endtask
endmodule // scc_ctrl_model
`default_nettype wire

// >>> dv/scc_lane_asserts.sv
// Concurrent checks on the ports of one lane.
// Assumes one CLK domain with RST_N asynchronous and active low.
`timescale 1ns/1ns
`default_nettype none
`include "scc_regs.vh"
module scc_lane_asserts (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        RECONFIG_STROBE,
  input wire logic        RECONFIG_ACK,
  input wire logic        RECONFIG_IN_USE,
  input wire logic [15:0] RECONFIG_READ_DATA,
  input wire logic        RX_ANALOG_RESET_START,
  input wire logic        RX_ANALOG_RESET_COMPLETE,
  input wire logic        RX_RESET_COMPLETE,
  input wire logic        MARGIN_SCAN_ERROR_MASK,
  input wire logic        MARGIN_SCAN_ERROR_PULSE,
  input wire logic [1:0]  RX_PROBE_SELECT,
  input wire logic [6:0]  RX_PROBE_VALUE,
  input wire logic        RECOVERY_LOOP_FREEZE,
  input wire logic        PATTERN_ERROR_COUNT_CLEAR,
  input wire logic [15:0] PATTERN_ERROR_COUNT,
  input wire logic [3:0]  RX_BYTE_DISPARITY_IN,
  input wire logic [3:0]  RX_BYTE_CODE_VALID_N,
  input wire logic [3:0]  RX_BYTE_DISPARITY_FAULT,
  input wire logic [3:0]  RX_BYTE_INVALID_CODE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic [4:0] busy_len;
  // Busy length is counted, since a sixteen-fold repetition is too costly.
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      busy_len <= 5'h00;
    end else begin
      busy_len <= RECONFIG_IN_USE ? busy_len + 5'h01 : 5'h00;
    end
  end
  ack_single_pulse_a: assert property (RECONFIG_ACK |=> !RECONFIG_ACK)
    else $error("ack longer than one cycle");
  ack_latency_a: assert property ($rose(RECONFIG_STROBE) && !RECONFIG_IN_USE
    |-> !RECONFIG_ACK [*5] ##1 RECONFIG_ACK) else $error("ack latency wrong");
  read_data_hold_a: assert property ($changed(RECONFIG_READ_DATA) |-> RECONFIG_ACK)
    else $error("read data moved without ack");
  busy_length_a: assert property ($fell(RECONFIG_IN_USE) |-> busy_len == `SCC_BUSY_LEN)
    else $error("busy length wrong");
  analog_time_a: assert property ($fell(RX_ANALOG_RESET_START)
    |-> !RX_ANALOG_RESET_COMPLETE [*8] ##[10:14] RX_ANALOG_RESET_COMPLETE)
    else $error("analog reset time wrong");
  full_after_analog_a: assert property ($rose(RX_ANALOG_RESET_COMPLETE)
    |-> !RX_RESET_COMPLETE [*8] ##[1:4] RX_RESET_COMPLETE) else $error("rx done time wrong");
  scan_mask_quiet_a: assert property (MARGIN_SCAN_ERROR_MASK [*2] |=> !MARGIN_SCAN_ERROR_PULSE)
    else $error("masked error pulsed");
  freeze_holds_a: assert property ((RECOVERY_LOOP_FREEZE && RX_PROBE_SELECT == 2'h2) [*3]
    |=> $stable(RX_PROBE_VALUE)) else $error("phase moved while frozen");
  count_clear_a: assert property (PATTERN_ERROR_COUNT_CLEAR |=> PATTERN_ERROR_COUNT == 16'h0000)
    else $error("count not cleared");
  disparity_pass_a: assert property (RX_RESET_COMPLETE
    |=> RX_BYTE_DISPARITY_FAULT == $past(RX_BYTE_DISPARITY_IN)) else $error("disparity flag wrong");
  code_pass_a: assert property (RX_RESET_COMPLETE
    |=> RX_BYTE_INVALID_CODE == $past(RX_BYTE_CODE_VALID_N)) else $error("code flag wrong");
  cover property ($rose(RECONFIG_STROBE) ##[4:6] RECONFIG_ACK);
  cover property ($fell(RECONFIG_IN_USE));
  cover property (MARGIN_SCAN_ERROR_PULSE);
endmodule // scc_lane_asserts
bind scc_lane scc_lane_asserts u_asserts (.*);
`default_nettype wire

// >>> dv/tb_scc_lane.sv
// Self-checking bench for one lane of the channel control block.
// Assumes the lane, its checker and the controller model are compiled before it.
`timescale 1ns/1ns
`default_nettype none
`include "scc_regs.vh"
module tb_scc_lane;
  logic        CLK, RST_N, RECONFIG_STROBE, RECONFIG_WRITE_SELECT, RECONFIG_ACK;
  logic        RECONFIG_IN_USE, TX_ANALOG_RESET_START, TX_CODING_RESET_START;
  logic        TX_RESET_COMPLETE, RX_ANALOG_RESET_START, RX_CODING_RESET_START;
  logic        RX_ANALOG_RESET_COMPLETE, RX_RESET_COMPLETE, MARGIN_SCAN_RESET;
  logic        MARGIN_SCAN_TRIGGER, MARGIN_SCAN_ERROR_MASK, MARGIN_SCAN_ERROR_PULSE;
  logic        RX_INVERT, TX_INVERT, RX_EQUALISER_MODE, LINEAR_EQUALISER_RESET;
  logic        PATTERN_ERROR_COUNT_CLEAR, PATTERN_ERROR_FLAG, PATTERN_ERROR_INJECT;
  logic        RECOVERY_LOOP_FREEZE, RX_SERIAL_IN, TX_SERIAL_OUT;
  logic [1:0]  RX_PROBE_SELECT;
  logic [2:0]  LANE_LOOP_SELECT, RX_PATTERN_SELECT, TX_PATTERN_SELECT;
  logic [3:0]  RX_BYTE_DISPARITY_IN, RX_BYTE_CODE_VALID_N;
  logic [3:0]  RX_BYTE_DISPARITY_FAULT, RX_BYTE_INVALID_CODE;
  logic [6:0]  RX_PROBE_VALUE;
  logic [8:0]  RECONFIG_ADDRESS;
  logic [15:0] RECONFIG_WRITE_DATA, RECONFIG_READ_DATA, PATTERN_ERROR_COUNT, q;
  logic [15:0] shadow [512];
  logic [31:0] rnd;
  int          failures, checks_done, n;

  scc_lane dut (.*);
  scc_ctrl_model u_host (.*);

  // Free-running 20 MHz clock.
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  // The serial line and raw decoder flags change every cycle, like live traffic.
  always @(posedge CLK) begin
    #5;
    rnd = $urandom;
    {RX_SERIAL_IN, RX_BYTE_DISPARITY_IN, RX_BYTE_CODE_VALID_N} = rnd[8:0];
  end
  // Every comparison passes here so that the counts stay honest.
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      failures++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Next bit of the seven-stage pattern from the two earlier bits that feed it.
  function automatic logic prbs7_next(input logic [7:0] hist);
    return hist[7] ^ hist[6];
  endfunction
  // Pulse one start line and count cycles until that side reports done.
  task automatic time_reset(input int k);
    int cnt;
    int exp;
    cnt = 0;
    exp = (k % 2 == 0) ? `SCC_ANALOG_CYC + `SCC_CODING_CYC : `SCC_CODING_CYC;
    {TX_ANALOG_RESET_START, TX_CODING_RESET_START,
     RX_ANALOG_RESET_START, RX_CODING_RESET_START} = 4'h8 >> k;
    @(posedge CLK);
    #5;
    {TX_ANALOG_RESET_START, TX_CODING_RESET_START,
     RX_ANALOG_RESET_START, RX_CODING_RESET_START} = 4'h0;
    chk((k < 2 ? TX_RESET_COMPLETE : RX_RESET_COMPLETE) === 1'b0, "done kept");
    while ((k < 2 ? TX_RESET_COMPLETE : RX_RESET_COMPLETE) !== 1'b1 && cnt < 60) begin
      @(posedge CLK);
      #5;
      cnt++;
    end
    chk(cnt >= exp - 1 && cnt <= exp + 1, "reset time");
    if (k == 2) chk(RX_ANALOG_RESET_COMPLETE === 1'b1, "analog done low");
  endtask
  // Writes at random places, each read back, plus a neighbour that may be unwritten.
  task automatic rw_pass(input int cnt);
    logic [8:0]  a;
    logic [15:0] d;
    for (int i = 0; i < cnt; i++) begin
      {a, d} = 25'($urandom);
      if (i == 0) a = 9'h1ff;
      u_host.access(1'b1, a, d, q, n);
      shadow[a] = d;
      chk(n == `SCC_ACK_LAT + 2, "ack latency");
      u_host.access(1'b0, a, 16'h0000, q, n);
      chk(q === shadow[a], "read back");
      a = a ^ 9'h0aa;
      u_host.access(1'b0, a, 16'h0000, q, n);
      chk(q === shadow[a], "neighbour read");
    end
  endtask
  // Sweep loop, pattern, polarity and probe settings with errors injected.
  task automatic pattern_pass();
    int sf;
    int ss;
    logic [7:0] h;
    for (int p = 0; p < 9; p++) begin
      LANE_LOOP_SELECT = p[2:0];
      RX_PATTERN_SELECT = 3'(p % 4 + 1);
      TX_PATTERN_SELECT = RX_PATTERN_SELECT;
      {RX_PROBE_SELECT, RECOVERY_LOOP_FREEZE} = p[2:0];
      {TX_INVERT, RX_INVERT, RX_EQUALISER_MODE} = p[2:0] ^ 3'h5;
      PATTERN_ERROR_INJECT = 1'b1;
      MARGIN_SCAN_ERROR_MASK = (p == 8);
      {MARGIN_SCAN_RESET, LINEAR_EQUALISER_RESET} = 2'b11;
      @(posedge CLK);
      #5;
      {MARGIN_SCAN_RESET, LINEAR_EQUALISER_RESET} = 2'b00;
      MARGIN_SCAN_TRIGGER = 1'b1;
      repeat (3) @(posedge CLK);
      #5;
      MARGIN_SCAN_TRIGGER = 1'b0;
      sf = 0;
      ss = 0;
      repeat (200) begin
        @(posedge CLK);
        #5;
        if (PATTERN_ERROR_FLAG === 1'b1) sf++;
        if (MARGIN_SCAN_ERROR_PULSE === 1'b1) ss++;
      end
      chk(sf > 0, "no error flag");
      chk(PATTERN_ERROR_COUNT > 16'h0000, "count idle");
      chk((p == 8) ? ss == 0 : ss > 0, "scan pulses");
      PATTERN_ERROR_COUNT_CLEAR = 1'b1;
      @(posedge CLK);
      #5;
      PATTERN_ERROR_COUNT_CLEAR = 1'b0;
      chk(PATTERN_ERROR_COUNT === 16'h0000, "count kept");
    end
    // Clean loopback: without injection no error shows, and the line keeps its pattern.
    {LANE_LOOP_SELECT, TX_PATTERN_SELECT, RX_PATTERN_SELECT} = {3'h1, `SCC_PRBS7, `SCC_PRBS7};
    {TX_INVERT, RX_INVERT, PATTERN_ERROR_INJECT} = 3'h0;
    repeat (40) @(posedge CLK);
    #5;
    PATTERN_ERROR_COUNT_CLEAR = 1'b1;
    @(posedge CLK);
    #5;
    PATTERN_ERROR_COUNT_CLEAR = 1'b0;
    sf = 0;
    ss = 0;
    h = 8'h00;
    for (int c = 0; c < 100; c++) begin
      @(posedge CLK);
      #5;
      h = {h[6:0], TX_SERIAL_OUT};
      if (PATTERN_ERROR_FLAG !== 1'b0) sf++;
      if (c >= 7 && h[0] !== prbs7_next(h)) ss++;
    end
    chk(sf == 0 && PATTERN_ERROR_COUNT === 16'h0000, "clean errors");
    chk(ss == 0, "tx pattern");
  endtask
  // Main sequence: reset, reset timing, configuration space, patterns, busy.
  initial begin
    {TX_ANALOG_RESET_START, TX_CODING_RESET_START, RX_ANALOG_RESET_START,
     RX_CODING_RESET_START, MARGIN_SCAN_RESET, MARGIN_SCAN_TRIGGER, MARGIN_SCAN_ERROR_MASK,
     LANE_LOOP_SELECT, RX_INVERT, TX_INVERT, RX_EQUALISER_MODE, RX_PROBE_SELECT,
     LINEAR_EQUALISER_RESET, PATTERN_ERROR_COUNT_CLEAR, RX_PATTERN_SELECT,
     TX_PATTERN_SELECT, PATTERN_ERROR_INJECT, RECOVERY_LOOP_FREEZE, RX_SERIAL_IN,
     RX_BYTE_DISPARITY_IN, RX_BYTE_CODE_VALID_N} = '0;
    foreach (shadow[i]) shadow[i] = `SCC_CFG_RESET;
    failures = 0;
    checks_done = 0;
    RST_N = 1'b0;
    void'($urandom(63081));
    repeat (3) @(posedge CLK);
    #5;
    RST_N = 1'b1;
    chk(TX_RESET_COMPLETE === 1'b0 && RECONFIG_ACK === 1'b0, "reset outputs");
    for (int k = 0; k < 4; k++) time_reset(k);
    rw_pass(8);
    pattern_pass();
    n = 0;
    while (RECONFIG_IN_USE !== 1'b1 && n < 6000) begin
      @(posedge CLK);
      #5;
      n++;
    end
    chk(n < 6000, "busy never rose");
    u_host.access(1'b0, 9'h1ff, 16'h0000, q, n);
    chk(q === shadow[9'h1ff], "read after busy");
    complete_run();
  end
  // A hang ends the run here; the tests need well under this span.
  initial begin
    repeat (20000) @(posedge CLK);
    failures++;
    complete_run();
  end
endmodule // tb_scc_lane
`default_nettype wire
